// [hdl/sac_pkg.sv]
package sac_pkg;
    // Register indexes; each byte address is the index times four
    localparam logic [7:0] SAC_IDX_RESULT = 8'hD0;
    localparam logic [7:0] SAC_IDX_CTRL = 8'hD1;
    localparam logic [7:0] SAC_IDX_CHAN = 8'hE0;
    localparam logic [11:0] SAC_ADDR_RESULT = {2'h0, SAC_IDX_RESULT, 2'h0};
    localparam logic [11:0] SAC_ADDR_CTRL = {2'h0, SAC_IDX_CTRL, 2'h0};
    localparam logic [11:0] SAC_ADDR_CHAN = {2'h0, SAC_IDX_CHAN, 2'h0};
    localparam int SAC_AW = 12;

    // Control register fields
    localparam int SAC_BIT_IRQEN = 7;
    localparam int SAC_BIT_DONE = 6;
    localparam int SAC_BIT_START = 5;
    localparam int SAC_BIT_PWR = 4;
    localparam logic [7:0] SAC_CTRL_RESET = 8'h40;

    // Timing
    localparam int SAC_RES_BITS = 8;
    localparam int SAC_CODES = 256;
    localparam int SAC_CLK_DIV = 12;
    localparam int SAC_CORE_HZ = 20000000;
    localparam int SAC_OSC_REF_HZ = 8000000;
    localparam int SAC_CONV_TIME_NS = 70000;
    // Conversion clocks in 70 us at 8 MHz / 12, rounded down
    localparam int SAC_CONV_TICKS = (SAC_CONV_TIME_NS * (SAC_OSC_REF_HZ / 1000000)) / (SAC_CLK_DIV * 1000);
    localparam int SAC_CORE_PERIOD_NS = 1000000000 / SAC_CORE_HZ;
    // One decided bit per tick, so the whole conversion spans the typical time
    localparam int SAC_TICK_CYCLES = (SAC_CONV_TIME_NS / SAC_CORE_PERIOD_NS) / SAC_RES_BITS;
    localparam int SAC_IRQ_VECTOR = 4;
    localparam int SAC_CHANNELS = 8;

    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_CONV = 3'b010,
        SAC_SETTLE = 3'b100
    } sac_state_e;

    typedef struct packed {
        logic irqEn;
        logic done;
        logic pwrEn;
    } sac_ctrl_s;

    typedef struct packed {
        logic [SAC_CHANNELS-1:0] chanSel;
        logic cmpHigh;
    } sac_analog_s;
endpackage : sac_pkg

// [hdl/sac_sar_core.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_sar_core (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic tick,
    input wire logic cmpHigh,
    output logic busy,
    output logic finish,
    output logic [7:0] trial,
    output logic [7:0] code
);
    import sac_pkg::*;

    typedef struct packed {
        logic busy;
        logic finish;
        logic [7:0] trial;
        logic [7:0] bitMask;
        logic [7:0] code;
    } sac_core_s;

    sac_core_s cur;
    sac_core_s next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.finish = 1'b0;
        if (start) begin
            // Restart drops any running trial
            next_cur.busy = 1'b1;
            next_cur.bitMask = 8'h80;
            next_cur.trial = 8'h80;
        end else if (cur.busy && tick) begin
            // Keep the bit when input is above the trial level
            next_cur.trial = cmpHigh ? cur.trial : (cur.trial & ~cur.bitMask);
            next_cur.bitMask = cur.bitMask >> 1;
            next_cur.trial = next_cur.trial | next_cur.bitMask;
            if (cur.bitMask == 8'h01) begin
                next_cur.busy = 1'b0;
                next_cur.finish = 1'b1;
                next_cur.code = cmpHigh ? cur.trial : (cur.trial & ~cur.bitMask);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign busy = cur.busy;
    assign finish = cur.finish;
    assign trial = cur.trial;
    assign code = cur.code;
endmodule : sac_sar_core
`default_nettype wire

// [hdl/sac_adc_control.sv]
// Function
// - Eight-bit result by successive approximation, clocked at oscillator rate over twelve; here one bit per 175 core clocks.
// - One conversion takes typically 70 us at 8 MHz oscillator.
// - Writing one to start strobe begins conversion and clears done flag; here only if the same write also sets power.
// - Done flag sets when conversion finishes; result then valid.
// - Exactly one conversion per start strobe write, never self-started.
// - Start strobe during a conversion abandons it and restarts.
// - Start strobe is write-only; its read position returns zero.
// - Maskable interrupt on vector 4 when done sets, gated by enable.
// - Power enable zero powers converter down; one powers it.
// - Converter keeps running in WAIT; no automatic disable.
// - Reset aborts conversion, loads control 40h, interrupt enable zero.
// - Input channel chosen by one port line set to analog mode.
// - Completion interrupt can wake the processor from WAIT.
// - Result spans 256 equal steps between supply references.
// - Control register layout: enable b7, done b6, start b5, power b4.
// - Read-only result register holds all eight result bits.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_control (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sac_pkg::SAC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmpHighPin,
    input wire logic cpuWait,
    output logic [7:0] dacTrial,
    output logic converterPowered,
    output logic [sac_pkg::SAC_CHANNELS-1:0] analogChanSel,
    output logic doneIrq,
    output logic wakeReq
);
    import sac_pkg::*;

    function automatic logic hitAddr(input logic [SAC_AW-1:0] a, input logic [SAC_AW-1:0] reg_addr);
        hitAddr = (a == reg_addr);
    endfunction : hitAddr

    typedef struct packed {
        sac_ctrl_s ctrl;
        logic [7:0] result;
        logic [SAC_CHANNELS-1:0] chanSel;
        logic [7:0] tickCnt;
        logic [11:0] convCycles;
        logic [31:0] rdata;
        logic cmpMeta;
        logic cmpSync;
        sac_state_e state;
    } sac_top_s;

    sac_top_s cur;
    sac_top_s next_cur;

    logic busAccess;
    logic wrCtrl;
    logic startReq;
    logic tick;
    logic coreBusy;
    logic coreFinish;
    logic [7:0] coreCode;
    logic [7:0] coreTrial;
    logic mapped;

    // Single-cycle access phase: no wait states
    assign busAccess = psel && penable;
    assign mapped = hitAddr(paddr, SAC_ADDR_RESULT) || hitAddr(paddr, SAC_ADDR_CTRL) || hitAddr(paddr, SAC_ADDR_CHAN);
    assign wrCtrl = busAccess && pwrite && hitAddr(paddr, SAC_ADDR_CTRL);
    // Start ignored unless the same write sets power; settling is software's job
    assign startReq = wrCtrl && pwdata[SAC_BIT_START] && pwdata[SAC_BIT_PWR];
    assign tick = (cur.tickCnt == 8'(SAC_TICK_CYCLES - 1));

    sac_sar_core u_core (
        .core_clk(core_clk),
        .srst(srst),
        .start(startReq),
        .tick(tick),
        .cmpHigh(cur.cmpSync),
        .busy(coreBusy),
        .finish(coreFinish),
        .trial(coreTrial),
        .code(coreCode)
    );

    always_comb begin
        next_cur = cur;
        next_cur.cmpMeta = cmpHighPin;
        next_cur.cmpSync = cur.cmpMeta;
        // Conversion clock divider restarts with each start so timing is repeatable
        if (startReq || tick || !coreBusy) begin
            next_cur.tickCnt = 8'h00;
        end else begin
            next_cur.tickCnt = cur.tickCnt + 8'h01;
        end
        // Length of the running conversion, held against the tick budget
        if (startReq) begin
            next_cur.convCycles = 12'h000;
        end else if (coreBusy) begin
            next_cur.convCycles = cur.convCycles + 12'h001;
        end
        if (wrCtrl) begin
            next_cur.ctrl.irqEn = pwdata[SAC_BIT_IRQEN];
            next_cur.ctrl.pwrEn = pwdata[SAC_BIT_PWR];
            // An unpowered start is refused, so done must stay as it was
            if (startReq) begin
                next_cur.ctrl.done = 1'b0;
            end
        end
        if (busAccess && pwrite && hitAddr(paddr, SAC_ADDR_CHAN)) begin
            next_cur.chanSel = pwdata[SAC_CHANNELS-1:0];
        end
        if (coreFinish && !startReq) begin
            next_cur.ctrl.done = 1'b1;
            next_cur.result = coreCode;
        end
        unique case (cur.state)
            SAC_IDLE: begin
                if (startReq) next_cur.state = SAC_CONV;
            end
            SAC_CONV: begin
                if (coreFinish && !startReq) next_cur.state = SAC_SETTLE;
            end
            SAC_SETTLE: begin
                next_cur.state = startReq ? SAC_CONV : SAC_IDLE;
            end
            default: next_cur.state = SAC_IDLE;
        endcase
        next_cur.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (hitAddr(paddr, SAC_ADDR_RESULT)) begin
                next_cur.rdata[7:0] = cur.result;
            end else if (hitAddr(paddr, SAC_ADDR_CTRL)) begin
                next_cur.rdata[SAC_BIT_IRQEN] = cur.ctrl.irqEn;
                next_cur.rdata[SAC_BIT_DONE] = cur.ctrl.done;
                next_cur.rdata[SAC_BIT_START] = 1'b0;
                next_cur.rdata[SAC_BIT_PWR] = cur.ctrl.pwrEn;
            end else if (hitAddr(paddr, SAC_ADDR_CHAN)) begin
                next_cur.rdata[SAC_CHANNELS-1:0] = cur.chanSel;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
            cur.ctrl <= sac_ctrl_s'({SAC_CTRL_RESET[SAC_BIT_IRQEN], SAC_CTRL_RESET[SAC_BIT_DONE],
                SAC_CTRL_RESET[SAC_BIT_PWR]});
            cur.state <= SAC_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.rdata;
    assign pready = 1'b1;
    assign pslverr = busAccess && !mapped;
    // No WAIT input gating; the converter keeps running
    assign converterPowered = cur.ctrl.pwrEn;
    assign analogChanSel = cur.chanSel;
    assign dacTrial = coreTrial;
    // Level interrupt toward vector 4; same level wakes a waiting core
    assign doneIrq = cur.ctrl.irqEn && cur.ctrl.done;
    assign wakeReq = doneIrq && cpuWait;

    // Conversion control
    AST_DONE_SET: assert property (@(posedge core_clk) disable iff (srst)
        coreFinish && !startReq
        |=> cur.ctrl.done && cur.result == $past(coreCode))
        else $error("done or result not set at finish");

    AST_START_CLR: assert property (@(posedge core_clk) disable iff (srst)
        startReq
        |=> !cur.ctrl.done && coreBusy)
        else $error("start did not clear done or start core");

    AST_ONE_CONV: assert property (@(posedge core_clk) disable iff (srst)
        coreFinish && !startReq
        |=> !coreBusy)
        else $error("conversion restarted by itself");

    AST_RESTART: assert property (@(posedge core_clk) disable iff (srst)
        coreBusy && startReq
        |=> coreBusy && !coreFinish)
        else $error("restart did not abandon conversion");

    AST_CONV_LEN: assert property (@(posedge core_clk) disable iff (srst)
        coreFinish
        |-> cur.convCycles == 12'(SAC_RES_BITS * SAC_TICK_CYCLES))
        else $error("conversion length differs from tick budget");

    AST_TICK_BUSY: assert property (@(posedge core_clk) disable iff (srst)
        tick
        |-> coreBusy)
        else $error("tick outside a conversion");

    AST_TICK_IDLE: assert property (@(posedge core_clk) disable iff (srst)
        !coreBusy
        |=> cur.tickCnt == 8'h00)
        else $error("divider ran while idle");

    AST_TICK_MAX: assert property (@(posedge core_clk) disable iff (srst)
        1'b1
        |-> cur.tickCnt <= 8'(SAC_TICK_CYCLES - 1))
        else $error("divider passed its end count");

    AST_TRIAL_FIRST: assert property (@(posedge core_clk) disable iff (srst)
        startReq
        |=> dacTrial == 8'(1 << (SAC_RES_BITS - 1)))
        else $error("first trial is not the top bit");

    AST_TRIAL_IDLE: assert property (@(posedge core_clk) disable iff (srst)
        !coreBusy && !startReq
        |=> $stable(dacTrial))
        else $error("trial moved without a conversion");

    AST_BUSY_CONV: assert property (@(posedge core_clk) disable iff (srst)
        coreBusy
        |-> cur.state == SAC_CONV)
        else $error("core busy outside conversion state");

    AST_STATE_HOT: assert property (@(posedge core_clk) disable iff (srst)
        1'b1
        |-> $onehot(cur.state))
        else $error("state code not one-hot");

    AST_SYNC: assert property (@(posedge core_clk) disable iff (srst)
        !$past(srst)
        |-> cur.cmpSync == $past(cur.cmpMeta))
        else $error("comparator synchroniser skipped a stage");

    // Power and wait mode
    AST_PWR: assert property (@(posedge core_clk) disable iff (srst)
        wrCtrl
        |=> converterPowered == $past(pwdata[SAC_BIT_PWR]))
        else $error("power enable not applied");

    AST_UNPWR: assert property (@(posedge core_clk) disable iff (srst)
        wrCtrl && pwdata[SAC_BIT_START] && !pwdata[SAC_BIT_PWR] && !coreFinish
        |=> $stable(cur.ctrl.done))
        else $error("unpowered start changed done");

    AST_UNPWR_IDLE: assert property (@(posedge core_clk) disable iff (srst)
        wrCtrl && pwdata[SAC_BIT_START] && !pwdata[SAC_BIT_PWR] && !coreBusy
        |=> !coreBusy)
        else $error("unpowered start began a conversion");

    AST_WAIT_RUN: assert property (@(posedge core_clk) disable iff (srst)
        !wrCtrl
        |=> $stable(converterPowered))
        else $error("power changed without a write");

    // Interrupt and wake
    AST_IRQ: assert property (@(posedge core_clk) disable iff (srst)
        1'b1
        |-> doneIrq == (cur.ctrl.irqEn && cur.ctrl.done) && (!cur.ctrl.irqEn -> !doneIrq))
        else $error("interrupt not gated by enable");

    AST_WAKE: assert property (@(posedge core_clk) disable iff (srst)
        cpuWait && cur.ctrl.irqEn && cur.ctrl.done
        |-> wakeReq)
        else $error("waiting core not woken at completion");

    // Register bus
    AST_STA_RD0: assert property (@(posedge core_clk) disable iff (srst)
        psel && penable && !pwrite && paddr == SAC_ADDR_CTRL
        |-> !prdata[SAC_BIT_START])
        else $error("start bit read as one");

    AST_CTRL_RD: assert property (@(posedge core_clk) disable iff (srst)
        psel && !penable && !pwrite && hitAddr(paddr, SAC_ADDR_CTRL)
        |=> prdata[SAC_BIT_DONE] == $past(cur.ctrl.done) && prdata[SAC_BIT_PWR-1:0] == '0 && prdata[31:8] == '0)
        else $error("control read layout wrong");

    AST_RES_RD: assert property (@(posedge core_clk) disable iff (srst)
        psel && !penable && !pwrite && hitAddr(paddr, SAC_ADDR_RESULT)
        |=> prdata == {24'h000000, $past(cur.result)})
        else $error("result read wrong");

    AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (srst)
        !(psel && !penable && !pwrite)
        |=> prdata == 32'h0000_0000)
        else $error("read data stood past its cycle");

    AST_SLVERR: assert property (@(posedge core_clk) disable iff (srst)
        pslverr
        |-> psel && penable)
        else $error("error response outside access phase");

    AST_WR_DROP: assert property (@(posedge core_clk) disable iff (srst)
        busAccess && pwrite && !mapped && !coreFinish
        |=> $stable(cur.ctrl) && $stable(cur.chanSel))
        else $error("unmapped write landed");

    AST_RO_RESULT: assert property (@(posedge core_clk) disable iff (srst)
        busAccess && pwrite && hitAddr(paddr, SAC_ADDR_RESULT) && !coreFinish
        |=> $stable(cur.result))
        else $error("result register was written");

    AST_CHAN: assert property (@(posedge core_clk) disable iff (srst)
        busAccess && pwrite && hitAddr(paddr, SAC_ADDR_CHAN)
        |=> analogChanSel == $past(pwdata[SAC_CHANNELS-1:0]))
        else $error("channel select not applied");

    // Result and reset
    AST_RES_HOLD: assert property (@(posedge core_clk) disable iff (srst)
        !coreFinish
        |=> $stable(cur.result))
        else $error("result changed without completion");

    AST_RESET: assert property (@(posedge core_clk)
        $past(srst)
        |-> !cur.ctrl.irqEn && cur.ctrl.done && !coreBusy)
        else $error("reset state wrong");

    COV_CONV: cover property (@(posedge core_clk) disable iff (srst) coreFinish && !startReq);
    COV_ABORT: cover property (@(posedge core_clk) disable iff (srst) coreBusy && startReq);
    COV_IRQ: cover property (@(posedge core_clk) disable iff (srst) $rose(doneIrq));
    COV_UNPWR: cover property (@(posedge core_clk) disable iff (srst)
        wrCtrl && pwdata[SAC_BIT_START] && !pwdata[SAC_BIT_PWR]);
    COV_WAKE: cover property (@(posedge core_clk) disable iff (srst) $rose(wakeReq));
endmodule : sac_adc_control
`default_nettype wire

// [tb/sac_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
    input wire logic core_clk,
    input wire logic powered,
    input wire logic [7:0] chanSel,
    input wire logic [63:0] levels,
    input wire logic [7:0] trial,
    output logic cmpHigh
);
    logic flip = 1'b0;
    logic [7:0] lvl;
    // No defined input: comparator output wanders
    always @(posedge core_clk) flip <= ~flip;
    always_comb begin
        lvl = 8'h00;
        for (int i = 0; i < 8; i++) if (chanSel[i]) lvl = levels[8*i+:8];
        cmpHigh = (powered && $onehot(chanSel)) ? (lvl >= trial) : flip;
    end
endmodule : sac_analog_model
`default_nettype wire

// [tb/sac_adc_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_adc_control_tb;
    import sac_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpuWait = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hE80E;
    logic pready, pslverr, cmpHighPin, err, converterPowered, doneIrq, wakeReq;
    logic [7:0] dacTrial, chanSel, keep;
    logic [63:0] levels = 64'h0;
    int fails = 0, total_checks = 0, cyc = 0, t0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            finish_test();
        end
    end
    sac_adc_control dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmpHighPin(cmpHighPin), .cpuWait(cpuWait), .dacTrial(dacTrial), .converterPowered(converterPowered),
        .analogChanSel(chanSel), .doneIrq(doneIrq), .wakeReq(wakeReq));
    sac_analog_model ana (.core_clk(core_clk), .powered(converterPowered), .chanSel(chanSel),
        .levels(levels), .trial(dacTrial), .cmpHigh(cmpHighPin));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic finish_test();
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Channel first, then power and start strobe together in one control write
    task automatic start(input int c, input logic [7:0] lv, input logic ie);
        levels = {xs(), xs()};
        levels[8*c+:8] = lv;
        cpuWait <= xs() % 2;
        apb(1'b1, SAC_ADDR_CHAN, 32'h1 << c);
        apb(1'b1, SAC_ADDR_CTRL, {24'h0, ie, 7'h30});
        t0 = cyc;
        apb(1'b0, SAC_ADDR_CTRL, 32'h0);
        chk("ctrl after start", {24'h0, ie, 7'h10}, rd);
    endtask : start
    task automatic finish(input int c, input logic ie);
        int n;
        n = 0;
        do begin
            apb(1'b0, SAC_ADDR_CTRL, 32'h0);
            n++;
        end while (rd[6] !== 1'b1 && n < 700);
        chk("conv time ok", 1, (cyc - t0 >= 1380) && (cyc - t0 <= 1430));
        apb(1'b0, SAC_ADDR_RESULT, 32'h0);
        chk("result", {24'h0, levels[8*c+:8]}, rd);
        chk("irq", ie, doneIrq);
        chk("wake", ie & cpuWait, wakeReq);
    endtask : finish
    initial begin
        int c;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, SAC_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h40, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        apb(1'b1, SAC_ADDR_CTRL, 32'h20);
        apb(1'b0, SAC_ADDR_CTRL, 32'h0);
        chk("unpowered start", 32'h40, rd);
        chk("powered off", 0, converterPowered);
        for (int i = 0; i < 6; i++) begin
            c = xs() % 8;
            start(c, (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : xs(), i[0]);
            finish(c, i[0]);
        end
        // Restart mid-run: old result holds, new one lands
        keep = levels[8*c+:8];
        start(3, 8'h5A, 1'b1);
        repeat (500) @(posedge core_clk);
        apb(1'b0, SAC_ADDR_RESULT, 32'h0);
        chk("result held", {24'h0, keep}, rd);
        start(5, 8'hA5, 1'b1);
        finish(5, 1'b1);
        keep = dacTrial;
        repeat (3000) @(posedge core_clk);
        chk("no self start", keep, dacTrial);
        apb(1'b1, SAC_ADDR_RESULT, 32'hFF);
        apb(1'b0, SAC_ADDR_RESULT, 32'h0);
        chk("result ro", 32'hA5, rd);
        start(1, 8'h33, 1'b1);
        repeat (100) @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        repeat (1600) @(posedge core_clk);
        apb(1'b0, SAC_ADDR_CTRL, 32'h0);
        chk("ctrl mid reset", 32'h40, rd);
        apb(1'b0, SAC_ADDR_RESULT, 32'h0);
        chk("result aborted", 0, rd);
        finish_test();
    end
endmodule : sac_adc_control_tb
`default_nettype wire
